// *** hw/sfr_defs.svh ***
// Constants for the safety fault reaction manager
`ifndef SFR_DEFS_SVH
`define SFR_DEFS_SVH
// ----------------------------------------
// Structure
// ----------------------------------------
`define SFR_IN_MODS 2
`define SFR_IN_CH 8
`define SFR_OUT_MODS 2
`define SFR_OUT_CH 4
`define SFR_OUT_W 16
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SFR_ADDR_CONFIG 8'h00
`define SFR_ADDR_IN_FAULT_VAL 8'h04
`define SFR_ADDR_OUT_FAULT_VAL0 8'h08
`define SFR_ADDR_OUT_FAULT_VAL1 8'h0C
`define SFR_ADDR_TRIP_EXTEND 8'h10
`define SFR_ADDR_STATUS 8'h14
`define SFR_ADDR_IN_BAD 8'h18
`define SFR_ADDR_OUT_BAD 8'h1C
// ----------------------------------------
// Config fields and reset values
// ----------------------------------------
`define SFR_CFG_CPU_DUAL 0
`define SFR_CFG_IN_DUAL 1
`define SFR_CFG_OUT_DUAL 3
`define SFR_CFG_OUT_ANALOG 5
`define SFR_CONFIG_RESET 7'h00
`define SFR_IN_FAULT_RESET 16'h0000
`define SFR_OUT_FAULT_RESET 16'h0000
`define SFR_TRIP_EXT_RESET 8'h00
// ----------------------------------------
// Zero states
// ----------------------------------------
`define SFR_ZERO_DISCRETE 16'h0000
`define SFR_ZERO_ANALOG 16'h0000
`endif

// *** hw/sfr_pkg.sv ***
// Types shared by the safety fault reaction manager
package sfr_pkg;
   typedef enum logic [1:0] {LVL_NONE, LVL_MINOR, LVL_MAJOR,
                             LVL_FATAL} sfr_level_e;
   // Worst of two levels
   function automatic sfr_level_e sfr_worst(input sfr_level_e a,
                                            input sfr_level_e b);
      sfr_worst = (a > b) ? a : b;
   endfunction
endpackage

// *** hw/sfr_in_module.sv ***
// Fault reaction for one input module and its channels
`timescale 1ns/1ps
`include "sfr_defs.svh"
module sfr_in_module
   import sfr_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic dual,
   input wire logic [`SFR_IN_CH-1:0] rawIn,
   input wire logic [`SFR_IN_CH-1:0] faultVal,
   input wire logic modFault,
   input wire logic [`SFR_IN_CH-1:0] chHwFault,
   input wire logic [`SFR_IN_CH-1:0] chFieldFault,
   output logic [`SFR_IN_CH-1:0] value,
   output logic [`SFR_IN_CH-1:0] statusBad,
   output logic activeSide,
   output logic [1:0] failedSide,
   output sfr_level_e level
);
   logic [`SFR_IN_CH-1:0] next_value;
   logic [`SFR_IN_CH-1:0] next_statusBad;
   logic next_activeSide;
   logic [1:0] next_failedSide;
   sfr_level_e next_level;

   always_comb begin
      next_statusBad = statusBad;
      next_activeSide = activeSide;
      next_failedSide = failedSide;
      next_level = LVL_NONE;
      if (!dual) begin
         if (modFault) begin
            next_statusBad = {`SFR_IN_CH{1'b1}};
            next_level = LVL_MAJOR;
         end
         if (|(chHwFault | chFieldFault)) begin
            next_statusBad = next_statusBad | chHwFault | chFieldFault;
            next_level = LVL_MAJOR;
         end
      end else begin
         if (|chFieldFault) begin
            next_statusBad = statusBad | chFieldFault;
            next_level = LVL_MAJOR;
         end
         if (modFault || (|(chHwFault & ~chFieldFault))) begin
            // Failed side is marked in the same step as the switch
            next_failedSide[activeSide] = 1'b1;
            next_activeSide = ~activeSide;
            next_level = sfr_worst(next_level, LVL_MINOR);
         end
      end
      // Substitution follows the sticky status, so it holds after the event
      for (int i = 0; i < `SFR_IN_CH; i++) begin
         next_value[i] = next_statusBad[i] ? faultVal[i] : rawIn[i];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         value <= '0;
         statusBad <= '0;
         activeSide <= 1'b0;
         failedSide <= 2'b00;
         level <= LVL_NONE;
      end else begin
         value <= next_value;
         statusBad <= next_statusBad;
         activeSide <= next_activeSide;
         failedSide <= next_failedSide;
         level <= next_level;
      end
   end
endmodule // sfr_in_module

// *** hw/sfr_out_module.sv ***
// Fault reaction for one output module and its channels
`timescale 1ns/1ps
`include "sfr_defs.svh"
module sfr_out_module
   import sfr_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic dual,
   input wire logic analog,
   input wire logic shutdownAll,
   input wire logic [`SFR_OUT_W-1:0] faultVal,
   input wire logic [`SFR_OUT_CH-1:0] tripExtend,
   input wire logic [`SFR_OUT_CH*`SFR_OUT_W-1:0] appOut,
   input wire logic modFault,
   input wire logic [`SFR_OUT_CH-1:0] chHwFault,
   input wire logic [`SFR_OUT_CH-1:0] chFieldFault,
   input wire logic [`SFR_OUT_CH-1:0] chDangerProt,
   input wire logic [`SFR_OUT_CH-1:0] chDangerNoProt,
   output logic [`SFR_OUT_CH*`SFR_OUT_W-1:0] value,
   output logic [`SFR_OUT_CH-1:0] chDisable,
   output logic [`SFR_OUT_CH-1:0] statusBad,
   output logic activeSide,
   output logic [1:0] failedSide,
   output sfr_level_e level
);
   logic zeroMod;
   logic next_zeroMod;
   logic [`SFR_OUT_CH-1:0] chFail;
   logic [`SFR_OUT_CH-1:0] next_chFail;
   logic [`SFR_OUT_CH-1:0] chAny;
   logic [`SFR_OUT_CH-1:0] trip;
   logic [`SFR_OUT_W-1:0] zeroVal;
   logic [`SFR_OUT_CH*`SFR_OUT_W-1:0] next_value;
   logic next_activeSide;
   logic [1:0] next_failedSide;
   sfr_level_e next_level;

   always_comb begin
      // Dual modules treat only field faults the single way
      chAny = dual ? chFieldFault : (chHwFault | chFieldFault);
      trip = chAny & (chDangerProt | (chDangerNoProt & tripExtend));
      zeroVal = analog ? `SFR_ZERO_ANALOG : `SFR_ZERO_DISCRETE;
      next_zeroMod = zeroMod;
      next_chFail = chFail | chAny;
      next_activeSide = activeSide;
      next_failedSide = failedSide;
      next_level = LVL_NONE;
      if (|chAny) begin
         next_level = LVL_MAJOR;
      end
      if ((!dual && modFault) || (|trip)) begin
         next_zeroMod = 1'b1;
         next_level = LVL_MAJOR;
      end
      if (dual && (modFault || (|(chHwFault & ~chFieldFault)))) begin
         next_failedSide[activeSide] = 1'b1;
         next_activeSide = ~activeSide;
         next_level = sfr_worst(next_level, LVL_MINOR);
      end
      // Total shutdown outranks zeroing; zeroing outranks a channel value
      for (int i = 0; i < `SFR_OUT_CH; i++) begin
         if (shutdownAll) begin
            next_value[i*`SFR_OUT_W +: `SFR_OUT_W] = faultVal;
         end else if (next_zeroMod) begin
            next_value[i*`SFR_OUT_W +: `SFR_OUT_W] = zeroVal;
         end else if (next_chFail[i]) begin
            next_value[i*`SFR_OUT_W +: `SFR_OUT_W] = faultVal;
         end else begin
            next_value[i*`SFR_OUT_W +: `SFR_OUT_W] =
               appOut[i*`SFR_OUT_W +: `SFR_OUT_W];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         zeroMod <= 1'b0;
         chFail <= '0;
         value <= '0;
         chDisable <= '0;
         statusBad <= '0;
         activeSide <= 1'b0;
         failedSide <= 2'b00;
         level <= LVL_NONE;
      end else begin
         zeroMod <= next_zeroMod;
         chFail <= next_chFail;
         value <= next_value;
         chDisable <= {`SFR_OUT_CH{next_zeroMod}} | next_chFail;
         statusBad <= {`SFR_OUT_CH{next_zeroMod | shutdownAll}}
                      | next_chFail;
         activeSide <= next_activeSide;
         failedSide <= next_failedSide;
         level <= next_level;
      end
   end
endmodule // sfr_out_module

// *** hw/sfr_manager.sv ***
// Top of the safety fault reaction manager: CPU, levels, registers
`timescale 1ns/1ps
`include "sfr_defs.svh"
// Contract
// - Single CPU failure: stop CPU, all outputs to fault value, fatal.
// - Dual CPU failure: stop failing CPU, hand control to partner, minor.
// - Single input module failure: all channels fault value, bad, major.
// - Single channel or field failure: substitute failed channels, major.
// - Dual channel: field failure as single, other failures switch, minor.
// - Dual I/O module hardware failure: switch to standby, minor.
// - Single output module failure: channels zeroed, disabled, bad, major.
// - Shutoff switch trip: whole module zeroed, disabled, bad, major.
// - Channel failure, no trip: that channel fault value, disabled, major.
// - Zero state is false for discrete, 0.0 mA for analog current.
// - Trip on dangerous or protective failure; extendable per channel.
// - Minor error keeps running; failed unit marked before switch (code marks it in the same cycle as the switch).
module sfr_manager
   import sfr_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [31:0] regRdata,
   input wire logic cpuFault,
   input wire logic cpuFaultSide,
   input wire logic [`SFR_IN_MODS*`SFR_IN_CH-1:0] inRaw,
   input wire logic [`SFR_IN_MODS-1:0] inModFault,
   input wire logic [`SFR_IN_MODS*`SFR_IN_CH-1:0] inChHwFault,
   input wire logic [`SFR_IN_MODS*`SFR_IN_CH-1:0] inChFieldFault,
   input wire logic [`SFR_OUT_MODS*`SFR_OUT_CH*`SFR_OUT_W-1:0] appOut,
   input wire logic [`SFR_OUT_MODS-1:0] outModFault,
   input wire logic [`SFR_OUT_MODS*`SFR_OUT_CH-1:0] outChHwFault,
   input wire logic [`SFR_OUT_MODS*`SFR_OUT_CH-1:0] outChFieldFault,
   input wire logic [`SFR_OUT_MODS*`SFR_OUT_CH-1:0] outChDangerProt,
   input wire logic [`SFR_OUT_MODS*`SFR_OUT_CH-1:0] outChDangerNoProt,
   output logic [1:0] cpuStop,
   output logic activeCpu,
   output logic allShutdown,
   output logic [`SFR_IN_MODS*`SFR_IN_CH-1:0] inValue,
   output logic [`SFR_IN_MODS*`SFR_IN_CH-1:0] inStatusBad,
   output logic [`SFR_IN_MODS-1:0] inActiveSide,
   output logic [`SFR_OUT_MODS*`SFR_OUT_CH*`SFR_OUT_W-1:0] outValue,
   output logic [`SFR_OUT_MODS*`SFR_OUT_CH-1:0] outDisable,
   output logic [`SFR_OUT_MODS*`SFR_OUT_CH-1:0] outStatusBad,
   output logic [`SFR_OUT_MODS-1:0] outActiveSide,
   output sfr_level_e faultLevel
);
   // ----------------------------------------
   // Configuration registers
   // ----------------------------------------
   logic [6:0] cfgWord;
   logic [6:0] next_cfgWord;
   logic [15:0] inFaultVal;
   logic [15:0] next_inFaultVal;
   logic [`SFR_OUT_W-1:0] outFaultVal0;
   logic [`SFR_OUT_W-1:0] next_outFaultVal0;
   logic [`SFR_OUT_W-1:0] outFaultVal1;
   logic [`SFR_OUT_W-1:0] next_outFaultVal1;
   logic [7:0] tripExtend;
   logic [7:0] next_tripExtend;
   logic [31:0] next_regRdata;

   logic cpuDual;
   logic [1:0] inDual;
   logic [1:0] outDual;
   logic [1:0] outAnalog;

   assign cpuDual = cfgWord[`SFR_CFG_CPU_DUAL];
   assign inDual = cfgWord[`SFR_CFG_IN_DUAL +: 2];
   assign outDual = cfgWord[`SFR_CFG_OUT_DUAL +: 2];
   assign outAnalog = cfgWord[`SFR_CFG_OUT_ANALOG +: 2];

   // ----------------------------------------
   // CPU reaction state
   // ----------------------------------------
   logic [1:0] next_cpuStop;
   logic next_activeCpu;
   logic next_allShutdown;
   sfr_level_e cpuLevel;
   sfr_level_e next_faultLevel;

   // Per-module results from the leaf reactions, and per-module output fault values
   logic [`SFR_IN_MODS*2-1:0] inFailed;
   logic [`SFR_OUT_MODS*2-1:0] outFailed;
   sfr_level_e inLevel [`SFR_IN_MODS];
   sfr_level_e outLevel [`SFR_OUT_MODS];
   logic [`SFR_OUT_W-1:0] outFaultSel [`SFR_OUT_MODS];

   assign outFaultSel[0] = outFaultVal0;
   assign outFaultSel[1] = outFaultVal1;

   // ----------------------------------------
   // Register bus
   // ----------------------------------------
   always_comb begin
      next_cfgWord = cfgWord;
      next_inFaultVal = inFaultVal;
      next_outFaultVal0 = outFaultVal0;
      next_outFaultVal1 = outFaultVal1;
      next_tripExtend = tripExtend;
      next_regRdata = 32'h0000_0000;
      if (regWrite) begin
         case (regAddr)
            `SFR_ADDR_CONFIG: next_cfgWord = regWdata[6:0];
            `SFR_ADDR_IN_FAULT_VAL: next_inFaultVal = regWdata[15:0];
            `SFR_ADDR_OUT_FAULT_VAL0: next_outFaultVal0 = regWdata[15:0];
            `SFR_ADDR_OUT_FAULT_VAL1: next_outFaultVal1 = regWdata[15:0];
            `SFR_ADDR_TRIP_EXTEND: next_tripExtend = regWdata[7:0];
            default: begin
            end
         endcase
      end
      // Unmapped addresses read as zero
      if (regRead) begin
         case (regAddr)
            `SFR_ADDR_CONFIG: next_regRdata = {25'h0, cfgWord};
            `SFR_ADDR_IN_FAULT_VAL: next_regRdata = {16'h0, inFaultVal};
            `SFR_ADDR_OUT_FAULT_VAL0: next_regRdata = {16'h0, outFaultVal0};
            `SFR_ADDR_OUT_FAULT_VAL1: next_regRdata = {16'h0, outFaultVal1};
            `SFR_ADDR_TRIP_EXTEND: next_regRdata = {24'h0, tripExtend};
            `SFR_ADDR_STATUS: begin
               next_regRdata = {14'h0, outFailed, inFailed, outActiveSide,
                                inActiveSide, allShutdown, activeCpu,
                                cpuStop, faultLevel};
            end
            `SFR_ADDR_IN_BAD: next_regRdata = {16'h0, inStatusBad};
            `SFR_ADDR_OUT_BAD: next_regRdata = {16'h0, outDisable,
                                                outStatusBad};
            default: next_regRdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         cfgWord <= `SFR_CONFIG_RESET;
         inFaultVal <= `SFR_IN_FAULT_RESET;
         outFaultVal0 <= `SFR_OUT_FAULT_RESET;
         outFaultVal1 <= `SFR_OUT_FAULT_RESET;
         tripExtend <= `SFR_TRIP_EXT_RESET;
         regRdata <= 32'h0000_0000;
      end else begin
         cfgWord <= next_cfgWord;
         inFaultVal <= next_inFaultVal;
         outFaultVal0 <= next_outFaultVal0;
         outFaultVal1 <= next_outFaultVal1;
         tripExtend <= next_tripExtend;
         regRdata <= next_regRdata;
      end
   end

   // ----------------------------------------
   // CPU reaction
   // ----------------------------------------
   always_comb begin
      next_cpuStop = cpuStop;
      next_activeCpu = activeCpu;
      next_allShutdown = allShutdown;
      cpuLevel = LVL_NONE;
      if (cpuFault) begin
         // Losing the last running CPU is fatal even when dual
         if (!cpuDual || cpuStop[~cpuFaultSide]) begin
            next_cpuStop = 2'b11;
            next_allShutdown = 1'b1;
            cpuLevel = LVL_FATAL;
         end else begin
            next_cpuStop[cpuFaultSide] = 1'b1;
            next_activeCpu = ~cpuFaultSide;
            cpuLevel = LVL_MINOR;
         end
      end
   end

   // ----------------------------------------
   // Fault level of the latest event
   // ----------------------------------------
   always_comb begin
      sfr_level_e worst;
      worst = cpuLevel;
      for (int m = 0; m < `SFR_IN_MODS; m++) begin
         worst = sfr_worst(worst, inLevel[m]);
      end
      for (int m = 0; m < `SFR_OUT_MODS; m++) begin
         worst = sfr_worst(worst, outLevel[m]);
      end
      next_faultLevel = (worst != LVL_NONE) ? worst : faultLevel;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         cpuStop <= 2'b00;
         activeCpu <= 1'b0;
         allShutdown <= 1'b0;
         faultLevel <= LVL_NONE;
      end else begin
         cpuStop <= next_cpuStop;
         activeCpu <= next_activeCpu;
         allShutdown <= next_allShutdown;
         faultLevel <= next_faultLevel;
      end
   end

   // ----------------------------------------
   // Input module reactions
   // ----------------------------------------
   // Fault values are straight substitutions; choosing them is up to the
   // configurer (false for shutdown-demand inputs).
   generate
      for (genvar m = 0; m < `SFR_IN_MODS; m++) begin : gInMod
         sfr_in_module uIn (
            .clk(clk),
            .reset(reset),
            .dual(inDual[m]),
            .rawIn(inRaw[m*`SFR_IN_CH +: `SFR_IN_CH]),
            .faultVal(inFaultVal[m*`SFR_IN_CH +: `SFR_IN_CH]),
            .modFault(inModFault[m]),
            .chHwFault(inChHwFault[m*`SFR_IN_CH +: `SFR_IN_CH]),
            .chFieldFault(inChFieldFault[m*`SFR_IN_CH +: `SFR_IN_CH]),
            .value(inValue[m*`SFR_IN_CH +: `SFR_IN_CH]),
            .statusBad(inStatusBad[m*`SFR_IN_CH +: `SFR_IN_CH]),
            .activeSide(inActiveSide[m]),
            .failedSide(inFailed[m*2 +: 2]),
            .level(inLevel[m])
         );
      end
   endgenerate

   // ----------------------------------------
   // Output module reactions
   // ----------------------------------------
   // Related-module shutdown on bad status is left to the application.
   generate
      for (genvar m = 0; m < `SFR_OUT_MODS; m++) begin : gOutMod
         sfr_out_module uOut (
            .clk(clk),
            .reset(reset),
            .dual(outDual[m]),
            .analog(outAnalog[m]),
            .shutdownAll(allShutdown),
            .faultVal(outFaultSel[m]),
            .tripExtend(tripExtend[m*`SFR_OUT_CH +: `SFR_OUT_CH]),
            .appOut(appOut[m*`SFR_OUT_CH*`SFR_OUT_W +:
                           `SFR_OUT_CH*`SFR_OUT_W]),
            .modFault(outModFault[m]),
            .chHwFault(outChHwFault[m*`SFR_OUT_CH +: `SFR_OUT_CH]),
            .chFieldFault(outChFieldFault[m*`SFR_OUT_CH +: `SFR_OUT_CH]),
            .chDangerProt(outChDangerProt[m*`SFR_OUT_CH +: `SFR_OUT_CH]),
            .chDangerNoProt(outChDangerNoProt[m*`SFR_OUT_CH +: `SFR_OUT_CH]),
            .value(outValue[m*`SFR_OUT_CH*`SFR_OUT_W +:
                            `SFR_OUT_CH*`SFR_OUT_W]),
            .chDisable(outDisable[m*`SFR_OUT_CH +: `SFR_OUT_CH]),
            .statusBad(outStatusBad[m*`SFR_OUT_CH +: `SFR_OUT_CH]),
            .activeSide(outActiveSide[m]),
            .failedSide(outFailed[m*2 +: 2]),
            .level(outLevel[m])
         );
      end
   endgenerate
endmodule // sfr_manager

// *** tb/sfr_partner.sv ***
// Field side and application model for the fault reaction manager
`timescale 1ns/1ps
module sfr_partner (
   input wire logic clk,
   input wire logic reset,
   input wire logic [7:0] outStatusBad,
   output logic [15:0] inRaw,
   output logic [127:0] appOut
);
   logic [127:0] next_appOut;
   // Contacts held steady so substituted bits stand out
   assign inRaw = 16'h3C96;
   always_comb begin
      next_appOut = appOut;
      // De-energised is safe, so any bad channel drops every output
      if (|outStatusBad) begin
         next_appOut = '0;
      end
   end
   always_ff @(posedge clk) begin
      if (reset) begin
         appOut <= {8{16'hA55A}};
      end else begin
         appOut <= next_appOut;
      end
   end
endmodule // sfr_partner

// *** tb/sfr_manager_checker.sv ***
// Port assertions for the fault reaction manager
`timescale 1ns/1ps
`include "sfr_defs.svh"
module sfr_manager_checker
   import sfr_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWrite,
   input wire logic cpuFault,
   input wire logic cpuFaultSide,
   input wire logic [1:0] inModFault,
   input wire logic [15:0] inChHwFault,
   input wire logic [15:0] inChFieldFault,
   input wire logic [1:0] outModFault,
   input wire logic [7:0] outChHwFault,
   input wire logic [7:0] outChDangerProt,
   input wire logic [7:0] outChDangerNoProt,
   input wire logic [1:0] cpuStop,
   input wire logic activeCpu,
   input wire logic allShutdown,
   input wire logic [15:0] inStatusBad,
   input wire logic [1:0] inActiveSide,
   input wire logic [127:0] outValue,
   input wire logic [7:0] outDisable,
   input wire logic [7:0] outStatusBad,
   input wire logic [1:0] outActiveSide,
   input wire sfr_level_e faultLevel
);
   // Mirror of the configuration, since it is not on the ports
   logic [6:0] cfg, next_cfg;
   logic [7:0] inHit;
   assign inHit = inChHwFault[7:0] | inChFieldFault[7:0];
   always_comb begin
      next_cfg = cfg;
      if (regWrite && regAddr == `SFR_ADDR_CONFIG) begin
         next_cfg = regWdata[6:0];
      end
   end
   always_ff @(posedge clk) begin
      if (reset) begin
         cfg <= 7'h00;
      end else begin
         cfg <= next_cfg;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   cpu_fatal_a: assert property (cpuFault && !cfg[0]
      |=> cpuStop == 2'b11 && allShutdown && faultLevel == LVL_FATAL)
      else $error("cpu fatal");
   shut_outputs_a: assert property (allShutdown
      |=> outStatusBad == 8'hFF) else $error("shutdown status");
   cpu_switch_a: assert property (cpuFault && cfg[0] && cpuStop == 2'b00
      |=> cpuStop == ($past(cpuFaultSide) ? 2'b10 : 2'b01)
      && activeCpu == !$past(cpuFaultSide) && faultLevel == LVL_MINOR)
      else $error("cpu switch");
   in_mod_bad_a: assert property (inModFault[0] && !cfg[1]
      |=> inStatusBad[7:0] == 8'hFF ##1 faultLevel == LVL_MAJOR)
      else $error("input module");
   in_chan_bad_a: assert property (|inHit && !cfg[1]
      |=> &(inStatusBad[7:0] | ~$past(inHit))) else $error("input channel");
   out_mod_zero_a: assert property (outModFault[0] && !cfg[3]
      && !cpuFault && !allShutdown |=> outDisable[3:0] == 4'hF
      && outValue[63:0] == '0) else $error("output module");
   out_trip_a: assert property (outChHwFault[5]
      && outChDangerProt[5] && !cfg[4] |=> outDisable[7:4] == 4'hF
      && outStatusBad[7:4] == 4'hF) else $error("output trip");
   out_no_trip_a: assert property (outChHwFault[5]
      && !outChDangerProt[5] && !cfg[4] && !outModFault[1]
      |=> outDisable[5] && outStatusBad[5]) else $error("channel fault");
   out_switch_a: assert property (outModFault[1] && cfg[4]
      |=> outActiveSide[1] != $past(outActiveSide[1])
      ##1 faultLevel == LVL_MINOR) else $error("output switch");
   level_hold_a: assert property (faultLevel != LVL_NONE
      |=> faultLevel != LVL_NONE) else $error("level lost");
   cover property (allShutdown);
   cover property (outDisable == 8'hF0);
   cover property (inActiveSide == 2'b11);
endmodule // sfr_manager_checker

// *** tb/sfr_manager_test.sv ***
// Directed bench for the fault reaction manager
`timescale 1ns/1ps
`include "sfr_defs.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
   $display("unexpected at %0t: %h vs %h", $time, (g), (e)); end end
module sfr_manager_test
   import sfr_pkg::*;
;
   logic clk = 0, reset = 1, regWrite = 0, regRead = 0;
   logic cpuFault = 0, cpuFaultSide = 0, activeCpu, allShutdown;
   logic [7:0] regAddr = 8'h00, outDisable, outStatusBad;
   logic [31:0] regWdata = 32'h0000_0000, regRdata, rdv;
   logic [1:0] inModFault = 0, outModFault = 0, cpuStop;
   logic [1:0] inActiveSide, outActiveSide;
   logic [15:0] inRaw, inChHwFault = 0, inChFieldFault = 0;
   logic [15:0] inValue, inStatusBad;
   logic [127:0] appOut, outValue, app0;
   logic [7:0] outChHwFault = 0, outChFieldFault = 0;
   logic [7:0] outChDangerProt = 0, outChDangerNoProt = 0;
   sfr_level_e faultLevel;
   int n_errors = 0, checks_done = 0, cycles = 0;
   always #50 clk = ~clk;
   sfr_manager DUT (.clk, .reset, .regAddr, .regWdata, .regWrite, .regRead,
      .regRdata, .cpuFault, .cpuFaultSide, .inRaw, .inModFault, .inChHwFault,
      .inChFieldFault, .appOut, .outModFault, .outChHwFault, .outChFieldFault,
      .outChDangerProt, .outChDangerNoProt, .cpuStop, .activeCpu, .allShutdown,
      .inValue, .inStatusBad, .inActiveSide, .outValue, .outDisable,
      .outStatusBad, .outActiveSide, .faultLevel);
   sfr_partner partner (.clk, .reset, .outStatusBad, .inRaw, .appOut);
   task end_of_test;
      if (n_errors == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Run is under two hundred cycles; far past that means a hang
   always @(posedge clk) begin
      cycles++;
      if (cycles == 8000) begin
         n_errors++;
         end_of_test();
      end
   end
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask
   task rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      #1 d = regRdata;
   endtask
   // Fault pulses last one cycle; returns in the first reaction cycle
   task fire;
      @(posedge clk);
      {cpuFault, inModFault, inChHwFault, inChFieldFault} <= '0;
      {outModFault, outChHwFault, outChFieldFault} <= '0;
      {outChDangerProt, outChDangerNoProt} <= '0;
      #1;
   endtask
   task lvl(input sfr_level_e e);
      @(posedge clk);
      #1 `CHK(faultLevel, e)
   endtask
   task rst(input logic [31:0] c);
      @(posedge clk);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      wr(`SFR_ADDR_CONFIG, c);
   endtask
   initial begin
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      for (int i = 0; i < 9; i++) begin
         rd(8'(i * 4), rdv);
         `CHK(rdv, 32'h0000_0000)
      end
      wr(`SFR_ADDR_CONFIG, 32'hFFFF_FFFF);
      wr(8'h20, 32'hFFFF_FFFF);
      wr(`SFR_ADDR_STATUS, 32'hFFFF_FFFF);
      rd(`SFR_ADDR_CONFIG, rdv);
      `CHK(rdv, 32'h0000_007F)
      rd(8'h20, rdv);
      `CHK(rdv, 32'h0000_0000)
      rd(`SFR_ADDR_STATUS, rdv);
      `CHK(rdv, 32'h0000_0000)
      rst(32'h0000_0000);
      wr(`SFR_ADDR_IN_FAULT_VAL, 32'h0000_A5A4);
      @(posedge clk);
      inModFault <= 2'b01;
      fire;
      `CHK(inStatusBad, 16'h00FF)
      `CHK(inValue, {inRaw[15:8], 8'hA4})
      lvl(LVL_MAJOR);
      rst(32'h0000_0000);
      @(posedge clk);
      inChHwFault <= 16'h0004;
      inChFieldFault <= 16'h0400;
      fire;
      `CHK(inStatusBad, 16'h0404)
      `CHK(inValue, inRaw & 16'hFBFB)
      lvl(LVL_MAJOR);
      rst(32'h0000_0006);
      @(posedge clk);
      inChHwFault <= 16'h0008;
      fire;
      `CHK({inActiveSide, inStatusBad}, 18'h1_0000)
      lvl(LVL_MINOR);
      @(posedge clk);
      inChFieldFault <= 16'h0010;
      fire;
      `CHK(inStatusBad, 16'h0010)
      lvl(LVL_MAJOR);
      @(posedge clk);
      inModFault <= 2'b10;
      fire;
      `CHK(inActiveSide, 2'b11)
      lvl(LVL_MINOR);
      rd(`SFR_ADDR_STATUS, rdv);
      `CHK(rdv[13:0], 14'h14C1)
      for (int i = 0; i < 2; i++) begin
         rst(i ? 32'h0000_0060 : 32'h0000_0000);
         wr(`SFR_ADDR_OUT_FAULT_VAL0, 32'h0000_BEEF);
         app0 = appOut;
         @(posedge clk);
         outModFault <= 2'b01;
         fire;
         `CHK(outValue[63:0], 64'h0000_0000_0000_0000)
         `CHK({outDisable, outStatusBad}, 16'h0F0F)
         `CHK(outValue[127:64], app0[127:64])
         lvl(LVL_MAJOR);
      end
      for (int i = 0; i < 3; i++) begin
         rst(32'h0000_0000);
         wr(`SFR_ADDR_TRIP_EXTEND, (i == 1) ? 32'h0000_0020 : 32'h0000_0000);
         wr(`SFR_ADDR_OUT_FAULT_VAL1, 32'h0000_C33C);
         @(posedge clk);
         outChHwFault <= 8'h20;
         outChDangerProt <= (i == 0) ? 8'h20 : 8'h00;
         outChDangerNoProt <= (i > 0) ? 8'h20 : 8'h00;
         fire;
         if (i < 2) begin
            `CHK({outDisable, outStatusBad}, 16'hF0F0)
            `CHK(outValue[127:64], 64'h0000_0000_0000_0000)
         end else begin
            `CHK({outDisable, outStatusBad}, 16'h2020)
            `CHK(outValue[95:80], 16'hC33C)
         end
         lvl(LVL_MAJOR);
      end
      rst(32'h0000_0018);
      @(posedge clk);
      outModFault <= 2'b10;
      fire;
      `CHK(outActiveSide, 2'b10)
      lvl(LVL_MINOR);
      @(posedge clk);
      outChHwFault <= 8'h01;
      fire;
      `CHK({outActiveSide, outStatusBad}, 10'h300)
      lvl(LVL_MINOR);
      @(posedge clk);
      outChFieldFault <= 8'h02;
      fire;
      `CHK({outDisable, outStatusBad}, 16'h0202)
      lvl(LVL_MAJOR);
      rd(`SFR_ADDR_STATUS, rdv);
      `CHK(rdv[17:14], 4'h5)
      rst(32'h0000_0001);
      @(posedge clk);
      cpuFaultSide <= 1'b1;
      cpuFault <= 1'b1;
      fire;
      `CHK({cpuStop, activeCpu, allShutdown}, 4'h8)
      `CHK(faultLevel, LVL_MINOR)
      rst(32'h0000_0000);
      wr(`SFR_ADDR_OUT_FAULT_VAL0, 32'h0000_1234);
      wr(`SFR_ADDR_OUT_FAULT_VAL1, 32'h0000_5678);
      @(posedge clk);
      cpuFault <= 1'b1;
      fire;
      `CHK({cpuStop, allShutdown}, 3'h7)
      `CHK(faultLevel, LVL_FATAL)
      @(posedge clk);
      #1 `CHK(outValue, {{4{16'h5678}}, {4{16'h1234}}})
      `CHK(outStatusBad, 8'hFF)
      repeat (3) @(posedge clk);
      #1 `CHK(faultLevel, LVL_FATAL)
      end_of_test();
   end
endmodule // sfr_manager_test
bind sfr_manager sfr_manager_checker chk (.clk, .reset, .regAddr, .regWdata,
   .regWrite, .cpuFault, .cpuFaultSide, .inModFault, .inChHwFault,
   .inChFieldFault, .outModFault, .outChHwFault, .outChDangerProt,
   .outChDangerNoProt, .cpuStop, .activeCpu, .allShutdown, .inStatusBad,
   .inActiveSide, .outValue, .outDisable, .outStatusBad, .outActiveSide,
   .faultLevel);
